// *** src/capture_map.svh ***
`ifndef CAPTURE_MAP_SVH
`define CAPTURE_MAP_SVH

// ==========================================
// Register byte offsets
`define REG_GAIN_WORD 8'h00
`define REG_GAIN_MAG 8'h04
`define REG_SAMPLE_A 8'h08
`define REG_SAMPLE_B 8'h0C
`define REG_SAMPLE_COUNT 8'h10

// ==========================================
// Field positions
`define GAIN_WORD_SHDN_BIT 8
`define GAIN_MAG_B_LSB 8
`define CHAN_B_FIELD_MSB 7
`define CHAN_B_FIELD_LSB 4
`define CHAN_A_FIELD_MSB 3
`define CHAN_A_FIELD_LSB 0

// ==========================================
// Reset values
`define GAIN_RESET 8'h00
`define SAMPLE_RESET 14'h0000
`define COUNT_RESET 16'h0000

// ==========================================
// Serial frame counts, in serial clock cycles
`define GAIN_BITS 4'h8
`define ADC_A_FIRST 6'h02
`define ADC_A_LAST 6'h0F
`define ADC_B_FIRST 6'h12
`define ADC_B_LAST 6'h1F
`define ADC_FRAME_LAST 6'h21

`endif

// *** src/capture_pkg.sv ***
package capture_pkg;

  // ==========================================
  // Carriers
  // Drive of a shared two-way serial line
  typedef struct packed {
    logic out;
    logic oe;
  } pin_drive_t;

  // Two converted channel results, channel A first
  typedef struct packed {
    logic [13:0] a;
    logic [13:0] b;
  } sample_pair_t;

  // ==========================================
  // Readout sequencer states
  typedef enum logic {
    RD_IDLE,
    RD_SHIFT
  } rd_state_t;

  // ==========================================
  // Register-side state
  typedef struct packed {
    logic sel_q;
    logic [7:0] gain;
    logic gain_tog;
    sample_pair_t analog;
    logic samp_tog;
    logic conv_seen;
    logic [15:0] count;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } ctrl_state_t;

  // Amplifier state on the rising serial edge
  typedef struct packed {
    logic [7:0] shift;
    logic [7:0] shadow;
    logic tog_seen;
  } amp_rise_t;

  // Converter state on the rising serial edge
  typedef struct packed {
    rd_state_t state;
    logic [5:0] cnt;
    logic conv_q;
    logic tog_seen;
    sample_pair_t shadow;
    sample_pair_t held;
    sample_pair_t out;
    logic conv_tog;
  } adc_rise_t;

endpackage

// *** src/sync_two_ff.sv ***
`timescale 1ns/10ps
// ==========================================
// Two-flop level synchroniser
module sync_two_ff #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  // First stage feeds only the second stage
  struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } st, next_st;

  // Shift one stage per edge
  always_comb begin
    next_st = st;
    next_st.meta = d;
    next_st.stable = st.meta;
  end

  // Register both stages
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign q = st.stable;

endmodule

// *** src/adc_readout.sv ***
`timescale 1ns/10ps
`include "capture_map.svh"
// ==========================================
// Converter side of the serial link, on the serial clock
module adc_readout (
  input wire logic sclk,
  input wire logic presetn,
  input wire logic convert,
  input wire capture_pkg::sample_pair_t analog,
  input wire logic analog_tog,
  output capture_pkg::pin_drive_t miso,
  output logic conv_tog
);

  capture_pkg::adc_rise_t st, next_st;
  capture_pkg::pin_drive_t drive, next_drive;
  logic tog_s; // Analog toggle after the crossing

  // ==========================================
  // Bit placed on the line at a given frame position
  function automatic capture_pkg::pin_drive_t frame_bit(
    input logic [5:0] pos,
    input capture_pkg::sample_pair_t word
  );
    capture_pkg::pin_drive_t r;
    logic [5:0] idx;
    r = '0;
    idx = '0;
    if (pos >= `ADC_A_FIRST && pos <= `ADC_A_LAST) begin
      idx = 6'(`ADC_A_LAST - pos);
      r.out = word.a[idx[3:0]];
      r.oe = 1'b1;
    end else if (pos >= `ADC_B_FIRST && pos <= `ADC_B_LAST) begin
      idx = 6'(`ADC_B_LAST - pos);
      r.out = word.b[idx[3:0]];
      r.oe = 1'b1;
    end
    return r;
  endfunction

  // Analog words are steady before their toggle arrives
  sync_two_ff #(.WIDTH(1)) u_tog_sync (
    .clk(sclk),
    .rst_n(presetn),
    .d(analog_tog),
    .q(tog_s)
  );

  // ==========================================
  // Sampling and frame sequencing
  always_comb begin
    next_st = st;
    next_st.conv_q = convert;
    next_st.tog_seen = tog_s;
    // Copy the analog words only once the toggle has settled
    if (tog_s != st.tog_seen) begin
      next_st.shadow = analog;
    end
    case (st.state)
      capture_pkg::RD_IDLE: begin
        next_st.cnt = '0;
      end
      capture_pkg::RD_SHIFT: begin
        // Frame ends after the last gap cycle, the line already released
        if (st.cnt == `ADC_FRAME_LAST) begin
          next_st.state = capture_pkg::RD_IDLE;
        end else begin
          next_st.cnt = st.cnt + 6'h01;
        end
      end
      default: begin
        next_st.state = capture_pkg::RD_IDLE;
      end
    endcase
    // A new strobe restarts the frame even mid-readout
    if (convert && !st.conv_q) begin
      next_st.held = st.shadow;
      next_st.out = st.held;
      next_st.state = capture_pkg::RD_SHIFT;
      next_st.cnt = '0;
      next_st.conv_tog = ~st.conv_tog;
    end
  end

  always_ff @(posedge sclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================
  // Line drive, changed on the falling edge
  always_comb begin
    next_drive = '0;
    if (st.state == capture_pkg::RD_SHIFT) begin
      next_drive = frame_bit(st.cnt, st.out);
    end
  end

  // If the clock stops mid-frame the line stays driven
  always_ff @(negedge sclk or negedge presetn) begin
    if (!presetn) begin
      drive <= '0;
    end else begin
      drive <= next_drive;
    end
  end

  assign miso = drive;
  assign conv_tog = st.conv_tog;

endmodule

// *** src/analog_capture_spi_control.sv ***
`timescale 1ns/10ps
`include "capture_map.svh"
// ==========================================
// Operation
// - Eight-bit gain word holds both channel fields
// - Field codes map to fixed inverting gains
// - Gain data sampled on rising clock, select low
// - Echo changes on each falling clock edge
// - Echo shifts out the previously loaded gain
// - New gain applied when select rises
// - Convert rising edge samples both channels together
// - Results read out after the next strobe
// - Two 14-bit two's complement results per readout
// - Line released two cycles around each result
module analog_capture_spi_control (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sclk,
  input wire logic mosi,
  input wire logic gain_amp_select_n,
  input wire logic gain_amp_shutdown,
  input wire logic sample_convert_strobe,
  output logic gain_amp_echo_out,
  output logic miso_out,
  output logic miso_oe
);

  // ==========================================
  // Declarations
  capture_pkg::ctrl_state_t st, next_st; // Register-side state
  capture_pkg::amp_rise_t amp, next_amp; // Amplifier shift state
  logic [3:0] bit_cnt; // Rising edges since select fell
  logic [3:0] next_bit_cnt;
  logic echo, next_echo; // Echo line flop
  logic amp_cnt_rst_n; // Clears the bit count while deselected
  logic sel_s; // Select after the crossing
  logic shdn_s; // Shutdown after the crossing
  logic conv_tog_s; // Conversion toggle after the crossing
  logic gain_tog_s; // Gain toggle on the serial side
  logic conv_tog; // Conversion toggle from the converter
  capture_pkg::pin_drive_t miso; // Converter line drive
  logic setup_phase; // APB setup cycle
  logic access_done; // APB access completes at this edge

  // ==========================================
  // Gain code to magnitude of the inverting gain
  function automatic logic [6:0] gain_magnitude(input logic [3:0] code);
    logic [6:0] m;
    case (code)
      4'h1: m = 7'h01;
      4'h2: m = 7'h02;
      4'h3: m = 7'h05;
      4'h4: m = 7'h0A;
      4'h5: m = 7'h14;
      4'h6: m = 7'h32;
      4'h7: m = 7'h64;
      // Zero code and undefined codes mute the channel
      default: m = 7'h00;
    endcase
    return m;
  endfunction

  // ==========================================
  // Crossings into the register clock
  sync_two_ff #(.WIDTH(3)) u_pin_sync (
    .clk(pclk),
    .rst_n(presetn),
    .d({gain_amp_select_n, gain_amp_shutdown, conv_tog}),
    .q({sel_s, shdn_s, conv_tog_s})
  );

  // Crossing of the gain toggle onto the serial clock
  sync_two_ff #(.WIDTH(1)) u_gain_sync (
    .clk(sclk),
    .rst_n(presetn),
    .d(st.gain_tog),
    .q(gain_tog_s)
  );

  // ==========================================
  // Converter readout
  adc_readout u_adc (
    .sclk(sclk),
    .presetn(presetn),
    .convert(sample_convert_strobe),
    .analog(st.analog),
    .analog_tog(st.samp_tog),
    .miso(miso),
    .conv_tog(conv_tog)
  );

  // ==========================================
  // Register side: APB slave, gain apply, sample count
  assign setup_phase = psel && !penable;
  assign access_done = psel && penable && st.pready;

  always_comb begin
    next_st = st;
    next_st.sel_q = sel_s;
    next_st.conv_seen = conv_tog_s;
    // One counted conversion per toggle edge
    if (conv_tog_s != st.conv_seen) begin
      next_st.count = st.count + 16'h0001;
    end
    // Shutdown holds the gain at its reset code
    if (shdn_s) begin
      if (st.gain != `GAIN_RESET) begin
        next_st.gain = `GAIN_RESET;
        next_st.gain_tog = ~st.gain_tog;
      end
    end else if (sel_s && !st.sel_q) begin
      // Shift word is static while deselected, so it is safe to take
      next_st.gain = amp.shift;
      next_st.gain_tog = ~st.gain_tog;
    end
    // Answer is prepared in setup so every output is a flop
    if (setup_phase) begin
      next_st.pready = 1'b1;
      next_st.pslverr = 1'b0;
      next_st.prdata = '0;
      case (paddr)
        `REG_GAIN_WORD: begin
          next_st.prdata[7:0] = st.gain;
          next_st.prdata[`GAIN_WORD_SHDN_BIT] = shdn_s;
        end
        `REG_GAIN_MAG: begin
          next_st.prdata[6:0] = gain_magnitude(
            st.gain[`CHAN_A_FIELD_MSB:`CHAN_A_FIELD_LSB]);
          next_st.prdata[`GAIN_MAG_B_LSB +: 7] = gain_magnitude(
            st.gain[`CHAN_B_FIELD_MSB:`CHAN_B_FIELD_LSB]);
        end
        `REG_SAMPLE_A: begin
          next_st.prdata[13:0] = st.analog.a;
        end
        `REG_SAMPLE_B: begin
          next_st.prdata[13:0] = st.analog.b;
        end
        `REG_SAMPLE_COUNT: begin
          next_st.prdata[15:0] = st.count;
        end
        // Unmapped offsets answer with an error and zero data
        default: begin
          next_st.pslverr = 1'b1;
        end
      endcase
    end else if (access_done) begin
      next_st.pready = 1'b0;
      next_st.pslverr = 1'b0;
      // Writes land only at the completing edge
      if (pwrite && !st.pslverr) begin
        case (paddr)
          // Channel A waits for its partner: a toggle per word would
          // cancel out when both land while the serial clock is stopped
          `REG_SAMPLE_A: begin
            next_st.analog.a = pwdata[13:0];
          end
          // Writing channel B hands the whole pair across
          `REG_SAMPLE_B: begin
            next_st.analog.b = pwdata[13:0];
            next_st.samp_tog = ~st.samp_tog;
          end
          // Status words ignore writes
          default: begin
            next_st.samp_tog = st.samp_tog;
          end
        endcase
      end
    end else begin
      next_st.pready = 1'b0;
      next_st.pslverr = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================
  // Amplifier shift register, rising serial edge
  always_comb begin
    next_amp = amp;
    next_amp.tog_seen = gain_tog_s;
    // Echo source follows the applied gain once its toggle settles
    if (gain_tog_s != amp.tog_seen) begin
      next_amp.shadow = st.gain;
    end
    if (!gain_amp_select_n) begin
      next_amp.shift = {amp.shift[6:0], mosi};
    end
  end

  always_ff @(posedge sclk or negedge presetn) begin
    if (!presetn) begin
      amp <= '0;
    end else begin
      amp <= next_amp;
    end
  end

  // ==========================================
  // Bit count, cleared whenever select is high
  // Select acts as an asynchronous clear, so the count is zero
  // at the start of every write without needing a clock edge
  assign amp_cnt_rst_n = presetn && !gain_amp_select_n;

  always_comb begin
    next_bit_cnt = bit_cnt;
    if (bit_cnt != `GAIN_BITS) begin
      next_bit_cnt = bit_cnt + 4'h1;
    end
  end

  always_ff @(posedge sclk or negedge amp_cnt_rst_n) begin
    if (!amp_cnt_rst_n) begin
      bit_cnt <= '0;
    end else begin
      bit_cnt <= next_bit_cnt;
    end
  end

  // ==========================================
  // Echo line, falling serial edge
  // The top bit is placed by a falling edge while deselected,
  // so it is ready for the very first rising edge of a write
  always_comb begin
    next_echo = 1'b0;
    if (bit_cnt != `GAIN_BITS) begin
      next_echo = amp.shadow[3'(4'h7 - bit_cnt)];
    end
  end

  always_ff @(negedge sclk or negedge presetn) begin
    if (!presetn) begin
      echo <= 1'b0;
    end else begin
      echo <= next_echo;
    end
  end

  // ==========================================
  // Outputs
  assign prdata = st.prdata;
  assign pready = st.pready;
  assign pslverr = st.pslverr;
  assign gain_amp_echo_out = echo;
  assign miso_out = miso.out;
  assign miso_oe = miso.oe;

endmodule

// *** tb/capture_monitor.sv ***
`timescale 1ns/10ps
// ==========================================
// Port checker for the capture control block
module capture_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic sclk,
  input wire logic gain_amp_select_n,
  input wire logic sample_convert_strobe,
  input wire logic gain_amp_echo_out,
  input wire logic miso_oe
);
  // ==========================================
  // Converter frame pieces, seen on rising serial edges
  // Two bit times with the shared line let go
  sequence line_released;
    !miso_oe [*2];
  endsequence
  // Fourteen driven bit times, split to keep repetitions short
  sequence result_word;
    miso_oe [*7] ##1 miso_oe [*7];
  endsequence

  // ==========================================
  // Register bus
  reset_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(presetn) |-> !pready && !pslverr && prdata == 32'h0)
    else $error("bus outputs not quiet after reset");
  bus_answer_a: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable |=> pready)
    else $error("no answer in the access cycle");
  ready_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("ready held longer than one cycle");
  error_with_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
    pslverr |-> pready)
    else $error("error flag without ready");
  unmapped_error_a: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable && paddr > 8'h10 |=> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  mapped_ok_a: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable && paddr <= 8'h10 && paddr[1:0] == 2'b00 |=> !pslverr)
    else $error("mapped access refused");

  // ==========================================
  // Serial side
  // Amplifier clock is slow enough that two register samples catch one high phase
  echo_fall_only_a: assert property (@(posedge pclk) disable iff (!presetn)
    sclk && $past(sclk) && !gain_amp_select_n && !$past(gain_amp_select_n)
    |-> $stable(gain_amp_echo_out))
    else $error("echo moved while serial clock high");
  frame_shape_a: assert property (@(posedge sclk) disable iff (!presetn)
    $rose(sample_convert_strobe) |=> line_released ##1 result_word ##1
    line_released ##1 result_word ##1 !miso_oe)
    else $error("converter drive window wrong");
endmodule

bind analog_capture_spi_control capture_monitor mon (.*);

// *** tb/spi_master_model.sv ***
`timescale 1ns/10ps
// ==========================================
// Serial master stand-in; the link clock runs only inside frames
module spi_master_model (
  output logic sclk,
  output logic mosi,
  output logic gain_amp_select_n,
  output logic sample_convert_strobe,
  input wire logic gain_amp_echo_out,
  input wire logic miso_out,
  input wire logic miso_oe
);
  // Slow half period for the amplifier, 48 ns period for the converter
  localparam int AMP_HALF = 52;
  localparam int ADC_HALF = 24;

  // Idle: amplifier deselected, clock, data and strobe all held low here
  initial begin
    sclk = 1'b0;
    mosi = 1'b0;
    gain_amp_select_n = 1'b1;
    sample_convert_strobe = 1'b0;
  end

  // Select high long enough for the apply to cross
  task automatic deselect();
    gain_amp_select_n = 1'b1;
    #200;
  endtask

  // One gain word, MSB first; keep leaves select low on purpose
  task automatic gain_write(input logic [7:0] w, input logic keep, output logic [7:0] echo);
    gain_amp_select_n = 1'b0;
    #AMP_HALF;
    for (int i = 7; i >= 0; i--) begin
      mosi = w[i];
      #AMP_HALF;
      sclk = 1'b1;
      echo[i] = gain_amp_echo_out;
      #AMP_HALF;
      sclk = 1'b0;
    end
    // Stop showing the last bit once the word is done
    mosi = ~mosi;
    #AMP_HALF;
    if (!keep) begin
      deselect();
    end
  endtask

  // Lead-in cycles let fresh samples cross, then strobe and 34 cycles
  task automatic readout(output logic [13:0] a, output logic [13:0] b, output int bad);
    bad = 0;
    for (int i = -5; i < 34; i++) begin
      if (i == 0) begin
        sample_convert_strobe = 1'b1;
      end
      #ADC_HALF;
      sclk = 1'b1;
      if (i >= 3 && i <= 16) begin
        a[16 - i] = miso_out;
      end
      if (i >= 19 && i <= 32) begin
        b[32 - i] = miso_out;
      end
      if (i > 0 && miso_oe !== ((i >= 3 && i <= 16) || (i >= 19 && i <= 32))) begin
        bad++;
      end
      #ADC_HALF;
      sclk = 1'b0;
      sample_convert_strobe = 1'b0;
    end
    #1;
    // Line must be let go once the frame is clocked out
    if (miso_oe !== 1'b0) begin
      bad++;
    end
  endtask
endmodule

// *** tb/analog_capture_spi_control_tb.sv ***
`timescale 1ns/10ps
// ==========================================
// Self-checking bench for the capture control block
module analog_capture_spi_control_tb;
  // Row: gain word and samples in, gain magnitudes out
  typedef struct {
    logic [7:0] gain;
    logic [13:0] a;
    logic [13:0] b;
    logic [31:0] mag;
  } row_t;
  // Codes 0-7 over both fields, then codes above the table
  row_t rows [5] = '{
    '{8'h70, 14'h2000, 14'h1FFF, 32'h6400},
    '{8'h61, 14'h1FFF, 14'h2000, 32'h3201},
    '{8'h52, 14'h3FFF, 14'h0001, 32'h1402},
    '{8'h43, 14'h2AAA, 14'h1555, 32'h0A05},
    '{8'h9F, 14'h0000, 14'h3FFF, 32'h0000}};
  logic pclk, presetn, psel, penable, pwrite, gain_amp_shutdown;
  logic [7:0] paddr, echo, prev_g;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, er, sclk, mosi, gain_amp_select_n, sample_convert_strobe;
  logic gain_amp_echo_out, miso_out, miso_oe;
  logic [13:0] sa, sb, prev_a, prev_b;
  int error_cnt, samples_checked, bad;

  // Register clock, 40 ns period
  always #20 pclk = ~pclk;

  analog_capture_spi_control dut (.*);
  spi_master_model bfm (.*);

  // ==========================================
  // Shared tasks
  task automatic final_report();
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  // One transfer; request held until ready is seen, result in rd and er
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    // A slave that never answers ends the run
    if (pready !== 1'b1) begin
      error_cnt++;
      final_report();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rd, exp);
    check({31'h0, er}, 32'h0);
  endtask

  // Hang guard
  initial begin
    #2000000;
    error_cnt++;
    final_report();
  end

  // ==========================================
  // Main sequence
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    gain_amp_shutdown = 1'b0;
    prev_g = 8'h00;
    prev_a = 14'h0000;
    prev_b = 14'h0000;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    // Every register starts at zero
    for (int k = 0; k < 5; k++) begin
      rd_chk(8'(4 * k), 32'h0);
    end
    // Table: samples in, frame shows the previous pair, then a gain word
    foreach (rows[i]) begin
      apb(1'b1, 8'h08, {18'h0, rows[i].a});
      apb(1'b1, 8'h0C, {18'h0, rows[i].b});
      rd_chk(8'h0C, {18'h0, rows[i].b});
      bfm.readout(sa, sb, bad);
      check({4'h0, sa, sb}, {4'h0, prev_a, prev_b});
      check(32'(bad), 32'h0);
      bfm.gain_write(rows[i].gain, 1'b0, echo);
      check({24'h0, echo}, {24'h0, prev_g});
      rd_chk(8'h00, {24'h0, rows[i].gain});
      rd_chk(8'h04, rows[i].mag);
      rd_chk(8'h10, 32'(i + 1));
      prev_a = rows[i].a;
      prev_b = rows[i].b;
      prev_g = rows[i].gain;
    end
    // Unmapped place: refused with zero data
    apb(1'b0, 8'h14, 32'h0);
    check(rd, 32'h0);
    check({31'h0, er}, 32'h1);
    // Writes to read-only places change nothing
    apb(1'b1, 8'h00, 32'hFF);
    apb(1'b1, 8'h10, 32'hFF);
    rd_chk(8'h00, 32'h9F);
    rd_chk(8'h10, 32'h5);
    // Word shifted in but select still low: old setting stays
    bfm.gain_write(8'h25, 1'b1, echo);
    rd_chk(8'h00, 32'h9F);
    bfm.deselect();
    rd_chk(8'h00, 32'h25);
    // Shutdown forces gain to zero and ignores a new word
    gain_amp_shutdown <= 1'b1;
    bfm.gain_write(8'h77, 1'b0, echo);
    rd_chk(8'h00, 32'h100);
    gain_amp_shutdown <= 1'b0;
    repeat (4) @(posedge pclk);
    rd_chk(8'h00, 32'h0);
    // Second reset mid-run clears the strobe count
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(8'h10, 32'h0);
    final_report();
  end
endmodule
